// [core/tw_master.sv]
// Two-wire bus master transmitter with Wishbone register access
// Contract
// [RQ1] Software requests START: flag-clear 1, start 1, stop 0, enable 1, reserved 0.
// [RQ2] A START request waits until the bus is free, then sends START.
// [RQ3] After START goes out, the flag is set and status 0x08 shown.
// [RQ4] Writing one to the flag clears it and lets the bus operation continue.
// [RQ5] Address with write bit enters send mode; with read bit enters receive mode.
// [RQ6] Software masks the prescaler bits before reading the status code.
// [RQ7] After address and write bit: flag set, 0x18 ack, 0x20 nack, 0x38 lost.
// [RQ8] Data write while flag low is dropped and sets write collision.
// [RQ9] Software loads the data register only while the flag is high.
// [RQ10] Software requests STOP: flag-clear 1, start 0, stop 1, enable 1.
// [RQ11] Repeated START reports 0x10 and keeps the bus for the next address.
// [RQ12] In 0x10, address with read bit is sent and receive mode follows.
// [RQ13] In 0x18..0x30, clearing with start and stop low sends the loaded byte.
// [RQ14] After a data byte: 0x28 when acknowledged, 0x30 when not.
// [RQ15] Clearing with start alone gives repeated START; stop alone gives STOP, stop self-clears.
// [RQ16] Clearing with start and stop both high gives STOP then START; stop self-clears.
// [RQ17] In 0x38, clear with start low releases bus; start high queues a START.
// [RQ18] Lost arbitration while addressed as slave reports 0x68, 0x78 or 0xB0.
// [RQ19] While the flag is set the bus transfer stays suspended.
// [RQ20] Write direction bit is low; acknowledge is data low, no acknowledge high.
// [RQ21] Bytes shift out most significant bit first, eight bits plus one ack clock.
`timescale 1ns/1ps
module tw_master
  import tw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  typedef struct packed {
    tw_fsm_type st;
    logic [1:0] ph;
    logic [3:0] bit_n;
    logic flag;
    logic ack_en;
    logic start_bit_field;
    logic stop_bit_field;
    logic wcol;
    logic en;
    logic ie;
    logic [7:0] shift;
    logic [7:0] code;
    logic [1:0] presc;
    logic [7:0] rate;
    logic [7:0] own;
    logic busy;
    logic addr_ph;
    logic rx_mode;
    logic rep;
    logic scl_oe;
    logic sda_oe;
    logic scl_o;
    logic sda_o;
    logic wb_ack;
    logic [31:0] wb_dat;
  } tw_regs_type;

  tw_regs_type q;
  tw_regs_type d;
  logic scl_f;
  logic scl_rise;
  logic scl_fall;
  logic sda_f;
  logic sda_rise;
  logic sda_fall;
  logic tick;
  logic req;
  logic wr;
  logic [2:0] sel;
  logic [7:0] rd_val;
  logic obit;
  logic adv;
  logic ack_seen;
  logic match_own;
  logic match_gc;

  // Register index: 1 ctrl, 2 status, 3 data, 4 rate, 5 own address, 0 unmapped
  function automatic logic [2:0] reg_sel(input logic [7:0] adr);
    if (adr == ADR_CTRL) begin
      return 3'h1;
    end else if (adr == ADR_STAT) begin
      return 3'h2;
    end else if (adr == ADR_DATA) begin
      return 3'h3;
    end else if (adr == ADR_RATE) begin
      return 3'h4;
    end else if (adr == ADR_OWN) begin
      return 3'h5;
    end else begin
      return 3'h0;
    end
  endfunction

  tw_sync u_scl_sync (
    .clk(clk),
    .rst(rst),
    .pin(scl_i),
    .level(scl_f),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  tw_sync u_sda_sync (
    .clk(clk),
    .rst(rst),
    .pin(sda_i),
    .level(sda_f),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  tw_tick u_tick (
    .clk(clk),
    .rst(rst),
    .clr(q.st == FSM_IDLE),
    .rate(q.rate),
    .presc(q.presc),
    .tick(tick)
  );

  always_comb begin
    d = q;
    d.wb_ack = 1'b0;
    d.scl_o = 1'b0;
    d.sda_o = 1'b0;
    req = wb_cyc_i & wb_stb_i & ~q.wb_ack;
    // A write lands at the edge where the master samples ack, while it still holds the request
    wr = wb_cyc_i & wb_stb_i & q.wb_ack & wb_we_i & wb_sel_i[0];
    sel = reg_sel(wb_adr_i);
    ack_seen = ~sda_f; // [RQ20]
    match_own = (q.shift[7:1] == q.own[7:1]);
    match_gc = (q.shift == 8'h00) & q.own[0];
    // Ninth bit: sender releases, receiver drives the ack level
    if (q.bit_n < 4'h8) begin
      obit = q.shift[7]; // [RQ21]
    end else if (q.rx_mode && !q.addr_ph) begin
      obit = ~q.ack_en;
    end else begin
      obit = 1'b1;
    end
    // High phases wait for the line so a stretching slave is honoured
    adv = tick & ((q.ph < 2'h2) | scl_f);

    case (sel)
      3'h1: rd_val = {q.flag, q.ack_en, q.start_bit_field, q.stop_bit_field, q.wcol, q.en, 1'b0, q.ie};
      3'h2: rd_val = {q.code[7:3], 1'b0, q.presc}; // [RQ6]
      3'h3: rd_val = q.shift;
      3'h4: rd_val = q.rate;
      3'h5: rd_val = q.own;
      default: rd_val = 8'h00;
    endcase
    if (req) begin
      d.wb_ack = 1'b1;
      d.wb_dat = wb_we_i ? 32'h00000000 : {24'h000000, rd_val};
    end

    if (wr) begin
      if (sel == 3'h1) begin
        if (wb_dat_i[CTL_FLAG]) begin
          d.flag = 1'b0; // [RQ4]
        end
        d.ack_en = wb_dat_i[CTL_ACK];
        d.start_bit_field = wb_dat_i[CTL_STA]; // [RQ1] [RQ10]
        d.stop_bit_field = wb_dat_i[CTL_STO];
        d.en = wb_dat_i[CTL_EN];
        d.ie = wb_dat_i[CTL_IE];
      end else if (sel == 3'h2) begin
        d.presc = wb_dat_i[1:0];
      end else if (sel == 3'h3) begin
        // Shift register doubles as data buffer, so loads mid-byte are refused
        if (q.flag) begin
          d.shift = wb_dat_i[7:0];
          d.wcol = 1'b0;
        end else begin
          d.wcol = 1'b1; // [RQ8]
        end
      end else if (sel == 3'h4) begin
        d.rate = wb_dat_i[7:0];
      end else if (sel == 3'h5) begin
        d.own = wb_dat_i[7:0];
      end
    end

    // Bus ownership by any master, from START and STOP on the lines
    if (sda_fall && scl_f) begin
      d.busy = 1'b1;
    end else if (sda_rise && scl_f) begin
      d.busy = 1'b0;
    end

    case (q.st)
      FSM_IDLE: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        d.code = ST_NONE;
        d.stop_bit_field = 1'b0;
        if (q.en && q.start_bit_field && !q.flag) begin
          d.st = FSM_WAIT_FREE;
        end
      end
      FSM_WAIT_FREE: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        if (!q.busy) begin
          d.st = FSM_START; // [RQ2]
          d.ph = 2'h2;
          d.rep = 1'b0;
        end
      end
      FSM_START: begin
        d.scl_oe = (q.ph == 2'h0);
        d.sda_oe = (q.ph >= 2'h2);
        if (tick) begin
          d.ph = q.ph + 2'h1;
          if (q.ph == 2'h3) begin
            d.st = FSM_HOLD;
            d.addr_ph = 1'b1;
            d.bit_n = 4'h0;
            d.code = q.rep ? ST_RSTART : ST_START; // [RQ3] [RQ11]
            d.flag = 1'b1;
            d.sda_oe = 1'b1;
            d.scl_oe = 1'b1;
          end
        end
      end
      FSM_BITS: begin
        d.scl_oe = (q.ph < 2'h2);
        // Data moves one cycle after the clock is low, so no edge looks like START or STOP
        d.sda_oe = (q.ph == 2'h0 && !q.scl_oe) ? q.sda_oe : ~obit;
        if (adv) begin
          d.ph = q.ph + 2'h1;
          if (q.ph == 2'h3 && q.bit_n < 4'h8) begin
            d.shift = {q.shift[6:0], sda_f}; // [RQ21]
            d.bit_n = q.bit_n + 4'h1;
            // Receive data bits are released by design, no arbitration there
            if (obit && !sda_f && (q.addr_ph || !q.rx_mode)) begin
              d.scl_oe = 1'b0;
              d.sda_oe = 1'b0;
              if (q.addr_ph) begin
                d.st = FSM_FOLLOW;
              end else begin
                d.st = FSM_LOST;
                d.code = ST_ARB_LOST; // [RQ7]
                d.flag = 1'b1;
              end
            end
          end else if (q.ph == 2'h3) begin
            d.st = FSM_HOLD;
            d.flag = 1'b1;
            d.addr_ph = 1'b0;
            d.scl_oe = 1'b1;
            d.sda_oe = q.sda_oe;
            if (q.addr_ph && !q.rx_mode) begin
              d.code = ack_seen ? ST_AW_ACK : ST_AW_NACK; // [RQ7]
            end else if (q.addr_ph) begin
              d.code = ack_seen ? ST_AR_ACK : ST_AR_NACK; // [RQ5]
            end else if (q.rx_mode) begin
              d.code = q.ack_en ? ST_DR_ACK : ST_DR_NACK;
            end else begin
              d.code = ack_seen ? ST_DW_ACK : ST_DW_NACK; // [RQ14]
            end
          end
        end
      end
      FSM_HOLD: begin
        // Clock held low keeps the transfer suspended
        d.scl_oe = 1'b1; // [RQ19]
        d.sda_oe = 1'b0;
        if (q.en && !q.flag) begin
          d.ph = 2'h0;
          if (q.stop_bit_field) begin
            d.st = FSM_STOP; // [RQ15] [RQ16]
          end else if (q.start_bit_field) begin
            d.st = FSM_START; // [RQ15]
            d.rep = 1'b1;
          end else begin
            d.st = FSM_BITS; // [RQ13]
            d.bit_n = 4'h0;
            if (q.addr_ph) begin
              d.rx_mode = q.shift[0]; // [RQ5] [RQ12] [RQ20]
            end else if (q.rx_mode) begin
              d.shift = DATA_RST;
            end
          end
        end
      end
      FSM_STOP: begin
        d.scl_oe = (q.ph == 2'h0);
        d.sda_oe = (q.ph < 2'h2);
        if (tick) begin
          d.ph = q.ph + 2'h1;
          if (q.ph == 2'h3) begin
            d.stop_bit_field = 1'b0; // [RQ15] [RQ16]
            d.rx_mode = 1'b0;
            d.st = q.start_bit_field ? FSM_WAIT_FREE : FSM_IDLE; // [RQ16]
          end
        end
      end
      FSM_FOLLOW: begin
        // Keep collecting the winning master's address byte
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        if (scl_rise && q.bit_n < 4'h8) begin
          d.shift = {q.shift[6:0], sda_f};
          d.bit_n = q.bit_n + 4'h1;
        end
        if (!q.busy) begin
          d.st = FSM_LOST;
          d.code = ST_ARB_LOST;
          d.flag = 1'b1;
        end else if (scl_fall && q.bit_n == 4'h8) begin
          if (q.ack_en && (match_own || match_gc)) begin
            d.st = FSM_FOLLOW_ACK;
            d.sda_oe = 1'b1;
            if (match_gc) begin
              d.code = ST_GC_ADDR; // [RQ18]
            end else if (q.shift[0]) begin
              d.code = ST_SR_ADDR; // [RQ18]
            end else begin
              d.code = ST_SW_ADDR; // [RQ18]
            end
          end else begin
            d.st = FSM_LOST;
            d.code = ST_ARB_LOST; // [RQ7]
            d.flag = 1'b1;
          end
        end
      end
      FSM_FOLLOW_ACK: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b1;
        if (scl_fall || !q.busy) begin
          d.sda_oe = 1'b0;
          d.st = FSM_LOST;
          d.flag = 1'b1; // [RQ18]
        end
      end
      FSM_LOST: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        d.rx_mode = 1'b0;
        d.addr_ph = 1'b0;
        if (q.en && !q.flag) begin
          d.st = q.start_bit_field ? FSM_WAIT_FREE : FSM_IDLE; // [RQ17]
        end
      end
      default: begin
        d.st = FSM_IDLE;
      end
    endcase

    // Disabling drops the bus at once, whatever is in progress
    if (!q.en) begin
      d.st = FSM_IDLE;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      d.rx_mode = 1'b0;
      d.addr_ph = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= FSM_IDLE;
      q.code <= ST_NONE;
      q.shift <= DATA_RST;
      q.rate <= RATE_RST;
      q.own <= OWN_RST;
      q.presc <= PRESC_RST;
      {q.flag, q.ack_en, q.start_bit_field, q.stop_bit_field, q.wcol, q.en} <= CTRL_RST[7:2];
      q.ie <= CTRL_RST[CTL_IE];
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.wb_dat;
  assign wb_ack_o = q.wb_ack;
  assign scl_o = q.scl_o;
  assign scl_oe = q.scl_oe;
  assign sda_o = q.sda_o;
  assign sda_oe = q.sda_oe;
endmodule

// [core/tw_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module tw_sync
  import tw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic lvl;
    logic rise;
    logic fall;
  } tw_sync_type;
  tw_sync_type q;
  tw_sync_type d;
  always_comb begin
    d = q;
    d.ff1 = pin;
    d.ff2 = q.ff1;
    d.ff3 = q.ff2;
    // A change counts only once the last two stages agree
    if (q.ff2 == q.ff3) begin
      d.lvl = q.ff3;
    end
    d.rise = d.lvl & ~q.lvl;
    d.fall = ~d.lvl & q.lvl;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{ff1: 1'b1, ff2: 1'b1, ff3: 1'b1, lvl: 1'b1, rise: 1'b0, fall: 1'b0};
    end else begin
      q <= d;
    end
  end
  assign level = q.lvl;
  assign rise = q.rise;
  assign fall = q.fall;
endmodule

// [core/tw_tick.sv]
// Quarter-bit tick generator scaled by rate and prescaler
`timescale 1ns/1ps
module tw_tick
  import tw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic [7:0] rate,
  input wire logic [1:0] presc,
  output logic tick
);
  typedef struct packed {
    logic [13:0] cnt;
    logic tick;
  } tw_tick_type;
  tw_tick_type q;
  tw_tick_type d;
  logic [13:0] limit;
  always_comb begin
    // Prescaler multiplies the count limit by 4 to the power presc; a tick comes every limit plus one cycles
    limit = {6'h00, rate} << {presc, 1'b0};
    d = q;
    d.tick = 1'b0;
    if (clr) begin
      d.cnt = 14'h0000;
    end else if (q.cnt >= limit) begin
      d.cnt = 14'h0000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 14'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign tick = q.tick;
endmodule

// [include/tw_pkg.sv]
// Shared constants and types of the two-wire master controller
package tw_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_DATA = 8'h08;
  localparam logic [7:0] ADR_RATE = 8'h0C;
  localparam logic [7:0] ADR_OWN = 8'h10;
  // Control register bit positions
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_WCOL = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [1:0] PRESC_RST = 2'h0;
  // Bus rate: the rate register counts quarter bit periods
  localparam int CLK_KHZ = 10000;
  localparam int BUS_KHZ = 100;
  localparam logic [7:0] RATE_RST = 8'((CLK_KHZ + 4 * BUS_KHZ - 1) / (4 * BUS_KHZ) - 1);
  // Status codes, prescaler bits zero
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_DW_ACK = 8'h28;
  localparam logic [7:0] ST_DW_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_DR_ACK = 8'h50;
  localparam logic [7:0] ST_DR_NACK = 8'h58;
  localparam logic [7:0] ST_SW_ADDR = 8'h68;
  localparam logic [7:0] ST_GC_ADDR = 8'h78;
  localparam logic [7:0] ST_SR_ADDR = 8'hB0;
  localparam logic [7:0] ST_NONE = 8'hF8;
  typedef enum logic [3:0] {
    FSM_IDLE = 4'h0,
    FSM_WAIT_FREE = 4'h1,
    FSM_START = 4'h2,
    FSM_BITS = 4'h3,
    FSM_HOLD = 4'h4,
    FSM_STOP = 4'h5,
    FSM_FOLLOW = 4'h6,
    FSM_FOLLOW_ACK = 4'h7,
    FSM_LOST = 4'h8
  } tw_fsm_type;
endpackage

// [test/test_two_wire_master_transmitter.sv]
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
module test_two_wire_master_transmitter;
  import tw_pkg::*;
  localparam logic [6:0] SADR = 7'h2A;
  localparam logic [7:0] RA [6] = '{ADR_CTRL, ADR_STAT, ADR_DATA, ADR_RATE, ADR_OWN, 8'h14};
  localparam logic [7:0] RV [6] = '{CTRL_RST, ST_NONE, DATA_RST, RATE_RST, OWN_RST, 8'h00};
  logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, scl_oe, sda_oe, pull, nack, lose, scl, sda;
  logic [7:0] wb_adr, q, b, last;
  logic [31:0] wb_dat, rd, seed;
  int n_mismatch, samples_checked, i;
  // Open-drain wires with pull-ups
  assign scl = !scl_oe;
  assign sda = !(sda_oe || pull);
  tw_master dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(rd), .wb_ack_o(wb_ack),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  tw_slave_model #(.ADDR(SADR)) far (.scl(scl), .sda(sda), .nack_data(nack), .lose(lose),
    .pull_low(pull), .last_byte(last));
  task automatic report_and_stop;
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    q = rd[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (k >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic wait_flag(input logic [7:0] exp);
    int k;
    logic s;
    k = 0;
    do begin
      bus(1'b0, ADR_CTRL, 8'h00);
      k++;
    end while (q[CTL_FLAG] !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      n_mismatch++;
      report_and_stop();
    end
    s = scl;
    repeat (40) @(posedge clk);
    chk({7'h0, s}, {7'h0, scl});
    bus(1'b0, ADR_STAT, 8'h00);
    chk(exp, q & 8'hF8);
  endtask
  function automatic logic [7:0] exp_code(input logic [7:0] d, input logic a, input logic nk);
    if (!a) return nk ? ST_DW_NACK : ST_DW_ACK;
    if (d[0]) return ST_AR_NACK;
    return d[7:1] == SADR ? ST_AW_ACK : ST_AW_NACK;
  endfunction
  task automatic send(input logic [7:0] d, input logic a);
    bus(1'b1, ADR_DATA, d);
    bus(1'b1, ADR_CTRL, 8'h84);
    wait_flag(exp_code(d, a, nack));
    if (!a) chk(d, last);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, nack, lose} = 5'h00;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    seed = 32'd12756;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      bus(1'b0, RA[i], 8'h00);
      chk(RV[i], q);
    end
    bus(1'b1, ADR_RATE, 8'h04);
    bus(1'b1, ADR_DATA, 8'h3C);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk(8'h08, q & 8'h08);
    bus(1'b0, ADR_DATA, 8'h00);
    chk(DATA_RST, q);
    bus(1'b1, ADR_CTRL, 8'hA4);
    wait_flag(ST_START);
    send({SADR, 1'b0}, 1'b1);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk(8'h00, q & 8'h08);
    // Edge patterns first, then random bytes; every byte gets a random acknowledge
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      b = i < 2 ? {8{i[0]}} : seed[7:0];
      nack <= seed[9];
      send(b, 1'b0);
    end
    bus(1'b1, ADR_CTRL, 8'hA4);
    wait_flag(ST_RSTART);
    send({SADR, 1'b1}, 1'b1);
    bus(1'b1, ADR_CTRL, 8'h94);
    i = 0;
    do begin
      bus(1'b0, ADR_CTRL, 8'h00);
      i++;
    end while (q[CTL_STO] !== 1'b0 && i < 500);
    if (i >= 500) begin
      n_mismatch++;
      report_and_stop();
    end
    chk(8'h00, q & 8'h10);
    repeat (20) @(posedge clk);
    chk(8'h03, {6'h0, scl, sda});
    bus(1'b1, ADR_CTRL, 8'hA4);
    wait_flag(ST_START);
    send({SADR ^ 7'h01, 1'b0}, 1'b1);
    bus(1'b1, ADR_CTRL, 8'hB4);
    wait_flag(ST_START);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk(8'h00, q & 8'h10);
    send({SADR, 1'b0}, 1'b1);
    // Rival master wins the first data bit; the lost byte starts with a one
    lose <= 1'b1;
    bus(1'b1, ADR_DATA, 8'h80);
    bus(1'b1, ADR_CTRL, 8'h84);
    wait_flag(ST_ARB_LOST);
    chk(8'h00, {6'h0, scl_oe, sda_oe});
    lose <= 1'b0;
    bus(1'b1, ADR_CTRL, 8'hA4);
    wait_flag(ST_START);
    bus(1'b1, ADR_CTRL, 8'h94);
    repeat (200) @(posedge clk);
    chk(8'h03, {6'h0, scl, sda});
    report_and_stop();
  end
endmodule

// [test/tw_master_assertions.sv]
// Port-level checks of the two-wire master
`timescale 1ns/1ps
module tw_master_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking @(posedge clk); endclocking
  property p_ack_next;
    disable iff (rst) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not acked");
  property p_ack_pulse;
    disable iff (rst) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_open_drain;
    disable iff (rst) scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  // Lines must be let go at once, or a reset mid-transfer hangs the bus
  property p_rst_idle;
    rst |=> !scl_oe && !sda_oe && !wb_ack_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("lines held in reset");
  property p_start_high;
    disable iff (rst) $rose(sda_oe) && !scl_oe |=> !scl_oe [*4];
  endproperty
  a_start_high: assert property (p_start_high) else $error("start too short");
  property p_stop_high;
    disable iff (rst) $fell(sda_oe) && !scl_oe |-> $past(scl_oe) == 1'b0;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop with clock low");
  property p_scl_low;
    disable iff (rst) $rose(scl_oe) |-> scl_oe [*8];
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too short");
  property p_scl_high;
    disable iff (rst) $fell(scl_oe) |-> !scl_oe [*8];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  c_ack: cover property (wb_ack_o);
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_stop: cover property ($fell(sda_oe) && !scl_oe);
endmodule
bind tw_master tw_master_assertions u_checks (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
  .sda_oe(sda_oe));

// [test/tw_slave_model.sv]
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_data,
  input wire logic lose,
  output logic pull_low,
  output logic [7:0] last_byte
);
  logic [7:0] sh = 8'h00;
  logic addr_phase = 1'b0;
  logic sel = 1'b0;
  int n = 0;
  initial begin
    pull_low = 1'b0;
    last_byte = 8'h00;
  end
  always @(negedge sda) begin
    if (scl) begin
      n = 0;
      addr_phase = 1'b1;
    end
  end
  // A rival master grabs the data line while the clock is low, and its release is its STOP
  always @(posedge lose) begin
    pull_low = 1'b1;
  end
  always @(negedge lose) begin
    pull_low = 1'b0;
  end
  // A stop deselects, so stray clocks before the next start are not acknowledged, though they still shift in and update last_byte
  always @(posedge sda) begin
    if (scl) begin
      sel = 1'b0;
      addr_phase = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (n < 8) begin
      sh = {sh[6:0], sda};
      n++;
    end else begin
      n = 0;
    end
  end
  always @(negedge scl) begin
    if (n == 8) begin
      if (addr_phase) begin
        sel = sh[7:1] == ADDR && !sh[0];
      end else begin
        last_byte = sh;
      end
      pull_low = sel && (addr_phase || !nack_data);
      addr_phase = 1'b0;
    end else begin
      pull_low = 1'b0;
    end
  end
endmodule
